// [logic/dispatch_pkg.sv]
// Constants, types and layouts of the process dispatch engine.
// Function
// - Descriptor spans at least 64 halfwords.
// - Descriptor segment comes from register bits 16-31.
// - Descriptor pointers are offsets in that segment.
// - One header per level, highest level first.
// - Header holds a head and tail pointer.
// - Head 1 ends list, head 0 is empty.
// - Word 0 names level, word 1 links onward.
// - Words 2-3 semaphore; zero segment means ready.
// - Word 4 abort flags fault the dispatch.
// - Word 5 points to last register set.
// - Table address words are restored, never saved.
// - Words 14-15 keep the interval timer copy.
// - Save mask at word 16 skips zero registers.
// - Fault vectors read as segment/offset pairs.
// - Words 60-62 hold hidden fault stack header.
// - Current pointer: level high, descriptor low.
package dispatch_pkg;

	// ----------------------------------------------------------
	// Ready list and descriptor layout
	// ----------------------------------------------------------
	localparam logic [15:0] END_MARK = 16'h0001;
	localparam logic [15:0] EMPTY_MARK = 16'h0000;
	localparam logic [15:0] HDR_STEP = 16'h0002;
	localparam logic [15:0] NO_DESC = 16'h0000;
	localparam int DESC_WORDS = 64;
	localparam int FETCH_N = 17;
	localparam logic [4:0] FETCH_LAST = 5'h10;
	// Descriptor words fetched on dispatch, slot 0 on the right.
	localparam logic [16:0][5:0] FETCH_OFS = {
		6'h3E, 6'h3D, 6'h3C, 6'h3B, 6'h3A, 6'h10, 6'h0F, 6'h0E,
		6'h0D, 6'h0C, 6'h0B, 6'h0A, 6'h05, 6'h04, 6'h03, 6'h02,
		6'h00};
	localparam int F_LEVEL = 0;
	localparam int F_SEMSEG = 1;
	localparam int F_SEMOFS = 2;
	localparam int F_ABORT = 3;
	localparam int F_REGSET = 4;
	localparam int F_DESCRIPTOR_TABLE_ADDR_2 = 5;
	localparam int F_DESCRIPTOR_TABLE_ADDR_3 = 7;
	localparam int F_TIMER = 9;
	localparam int F_MASK = 11;
	localparam int F_PAGEV = 12;
	localparam int F_FSTK = 14;
	localparam logic [5:0] TIMER_HI_OFS = 6'h0E;
	localparam logic [5:0] TIMER_LO_OFS = 6'h0F;
	localparam logic [5:0] DTAR_FIRST = 6'h0A;
	localparam logic [5:0] DTAR_LAST = 6'h0D;

	// ----------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_SEG = 8'h08;
	localparam logic [7:0] A_CUR = 8'h0C;
	localparam logic [7:0] A_TIMER = 8'h10;
	localparam logic [7:0] A_SEM = 8'h14;
	localparam logic [7:0] A_ABORT = 8'h18;
	localparam logic [7:0] A_DESCRIPTOR_TABLE_ADDR_2 = 8'h1C;
	localparam logic [7:0] A_DESCRIPTOR_TABLE_ADDR_3 = 8'h20;
	localparam logic [7:0] A_MASK = 8'h24;
	localparam logic [7:0] A_PAGEV = 8'h28;
	localparam logic [7:0] A_FSTK = 8'h2C;
	localparam logic [7:0] A_FSTKL = 8'h30;
	localparam logic [7:0] A_IRQS = 8'h34;
	localparam logic [7:0] A_IRQM = 8'h38;
	localparam int CTRL_START = 0;
	localparam int CTRL_SAVE = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------
	// Events
	// ----------------------------------------------------------
	localparam int EV_W = 6;
	localparam int EV_DISPATCH = 0;
	localparam int EV_IDLE = 1;
	localparam int EV_ABORT = 2;
	localparam int EV_WAITING = 3;
	localparam int EV_TIMER = 4;
	localparam int EV_LEVEL = 5;

	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_HDR = 4'h1,
		S_HDR_DATA = 4'h2,
		S_FET = 4'h3,
		S_FET_DATA = 4'h4,
		S_CHECK = 4'h5,
		S_SAVE_HI = 4'h6,
		S_SAVE_LO = 4'h7
	} eng_state_t;

	typedef struct packed {
		logic valid;
		logic we;
		logic [15:0] seg;
		logic [15:0] off;
		logic [15:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic ready;
		logic rvalid;
		logic [15:0] rdata;
	} mem_rsp_t;

endpackage

// [logic/save_count.sv]
// Counts the registers that a save mask marks for transfer.
`timescale 1ns/1ps
module save_count
	import dispatch_pkg::*;
#(
	parameter int W = 16
) (
	// Mask in
	input wire logic [W-1:0] mask,
	// Number of set bits out
	output logic [$clog2(W+1)-1:0] count
);

	// ----------------------------------------------------------
	// Population count
	// ----------------------------------------------------------
	always_comb begin
		count = '0;
		for (int i = 0; i < W; i++) begin
			count = count + $bits(count)'(mask[i]);
		end
	end

endmodule

// [logic/process_dispatch.sv]
// Process dispatch engine: ready list walk and descriptor fetch.
`timescale 1ns/1ps
module process_dispatch
	import dispatch_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Descriptor memory
	output mem_req_t mem_req,
	input wire mem_rsp_t mem_rsp,
	// Interrupt
	output logic irq
);

	typedef struct packed {
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] seg_reg;
		logic [31:0] cur_ptr;
		logic [31:0] timer;
		logic [EV_W-1:0] irq_stat;
		logic [EV_W-1:0] irq_mask;
		eng_state_t state;
		mem_req_t mem;
		logic [4:0] idx;
		logic [16:0][15:0] fetched;
		logic [15:0] level;
		logic [15:0] cand;
		logic [15:0] save_lo;
	} state_t;

	state_t s;
	state_t next_s;
	logic [4:0] reg_count;

	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] b);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			r[8*i +: 8] = b[i] ? d[8*i +: 8] : r[8*i +: 8];
		end
		return r;
	endfunction

	function automatic mem_req_t issue(input logic we,
		input logic [15:0] seg, input logic [15:0] off,
		input logic [15:0] d);
		return '{valid: 1'b1, we: we, seg: seg, off: off, wdata: d};
	endfunction

	// Slot offsets are added to the descriptor address in-segment.
	function automatic logic [15:0] word_at(input logic [15:0] base,
		input logic [5:0] ofs);
		return base + {10'h000, ofs};
	endfunction

	// Software reads how many registers the next restore will move.
	save_count #(
		.W(16)
	) save_count_inst (
		.mask(s.fetched[F_MASK]),
		.count(reg_count)
	);

	// ----------------------------------------------------------
	// Next state
	// ----------------------------------------------------------
	always_comb begin
		logic [EV_W-1:0] ev;
		logic [31:0] rd;
		logic [15:0] seg;
		logic [31:0] wr;
		logic hit;
		ev = '0;
		rd = '0;
		wr = '0;
		hit = 1'b1;
		next_s = s;
		seg = s.seg_reg[31:16];
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
		case (s.state)
		S_IDLE: begin
		end
		S_HDR, S_FET: begin
			if (mem_rsp.ready) begin
				next_s.mem.valid = 1'b0;
				next_s.state = (s.state == S_HDR) ? S_HDR_DATA
					: S_FET_DATA;
			end
		end
		S_HDR_DATA: begin
			if (mem_rsp.rvalid) begin
				if (mem_rsp.rdata == END_MARK) begin
					next_s.cur_ptr = {s.level, NO_DESC};
					ev[EV_IDLE] = 1'b1;
					next_s.state = S_IDLE;
				end else if (mem_rsp.rdata == EMPTY_MARK) begin
					next_s.level = s.level + HDR_STEP;
					next_s.mem = issue(1'b0, seg, s.level + HDR_STEP,
						16'h0000);
					next_s.state = S_HDR;
				end else begin
					next_s.cand = mem_rsp.rdata;
					next_s.idx = '0;
					next_s.mem = issue(1'b0, seg,
						word_at(mem_rsp.rdata, FETCH_OFS[0]), 16'h0000);
					next_s.state = S_FET;
				end
			end
		end
		S_FET_DATA: begin
			if (mem_rsp.rvalid) begin
				// Slots 4..16 hold register set, table addresses,
				// timer, mask, fault vectors and fault stack.
				next_s.fetched[s.idx] = mem_rsp.rdata;
				if (s.idx == FETCH_LAST) begin
					next_s.state = S_CHECK;
				end else begin
					next_s.idx = s.idx + 5'h01;
					next_s.mem = issue(1'b0, seg,
						word_at(s.cand, FETCH_OFS[s.idx + 5'h01]),
						16'h0000);
					next_s.state = S_FET;
				end
			end
		end
		S_CHECK: begin
			// A descriptor whose level word does not name this header
			// is still dispatched; the flag only reports the damage.
			if (s.fetched[F_LEVEL] != s.level) begin
				ev[EV_LEVEL] = 1'b1;
			end
			if (s.fetched[F_SEMSEG] != 16'h0000) begin
				ev[EV_WAITING] = 1'b1;
			end else if (s.fetched[F_ABORT] != 16'h0000) begin
				ev[EV_ABORT] = 1'b1;
			end else begin
				next_s.cur_ptr = {s.level, s.cand};
				next_s.timer = {s.fetched[F_TIMER],
					s.fetched[F_TIMER+1]};
				ev[EV_DISPATCH] = 1'b1;
			end
			next_s.state = S_IDLE;
		end
		S_SAVE_HI: begin
			if (mem_rsp.ready) begin
				next_s.mem = issue(1'b1, seg,
					word_at(s.cur_ptr[15:0], TIMER_LO_OFS), s.save_lo);
				next_s.state = S_SAVE_LO;
			end
		end
		S_SAVE_LO: begin
			if (mem_rsp.ready) begin
				next_s.mem.valid = 1'b0;
				next_s.state = S_IDLE;
			end
		end
		default: begin
			next_s.mem.valid = 1'b0;
			next_s.state = S_IDLE;
		end
		endcase
		// The timer runs while a descriptor is current, unless just loaded.
		if (s.cur_ptr[15:0] != NO_DESC && !ev[EV_DISPATCH]) begin
			next_s.timer = s.timer + 32'h0000_0001;
			if (s.timer == 32'hFFFF_FFFF) begin
				ev[EV_TIMER] = 1'b1;
			end
		end

		// ------------------------------------------------------
		// Register writes
		// ------------------------------------------------------
		if (!s.aw_have && awvalid) begin
			next_s.aw_have = 1'b1;
			next_s.aw_addr = awaddr;
		end
		if (!s.w_have && wvalid) begin
			next_s.w_have = 1'b1;
			next_s.w_data = wdata;
			next_s.w_strb = wstrb;
		end
		if (s.aw_have && s.w_have && !s.bvalid) begin
			next_s.aw_have = 1'b0;
			next_s.w_have = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			case (s.aw_addr)
			A_CTRL: begin
				wr = merge(32'h0, s.w_data, s.w_strb);
				if (s.state == S_IDLE && wr[CTRL_START]) begin
					// Scan starts at the recorded level.
					next_s.level = s.cur_ptr[31:16];
					next_s.mem = issue(1'b0, seg, s.cur_ptr[31:16],
						16'h0000);
					next_s.state = S_HDR;
				end else if (s.state == S_IDLE && wr[CTRL_SAVE] &&
					s.cur_ptr[15:0] != NO_DESC) begin
					// Only the timer copy is written back; the table
					// address words are left alone.
					next_s.save_lo = s.timer[15:0];
					next_s.mem = issue(1'b1, seg,
						word_at(s.cur_ptr[15:0], TIMER_HI_OFS),
						s.timer[31:16]);
					next_s.state = S_SAVE_HI;
				end
			end
			A_SEG: next_s.seg_reg = merge(s.seg_reg, s.w_data,
				s.w_strb);
			A_CUR: begin
				// Moving the pointer mid-walk would corrupt the scan.
				if (s.state == S_IDLE) begin
					next_s.cur_ptr = merge(s.cur_ptr, s.w_data,
						s.w_strb);
				end
			end
			A_TIMER: next_s.timer = merge(s.timer, s.w_data,
				s.w_strb);
			A_IRQM: next_s.irq_mask = EV_W'(merge({26'h0,
				s.irq_mask}, s.w_data, s.w_strb));
			A_STATUS, A_SEM, A_ABORT, A_DESCRIPTOR_TABLE_ADDR_2, A_DESCRIPTOR_TABLE_ADDR_3, A_MASK,
			A_PAGEV, A_FSTK, A_FSTKL, A_IRQS: begin
			end
			default: next_s.bresp = RESP_SLVERR;
			endcase
		end

		// ------------------------------------------------------
		// Register reads
		// ------------------------------------------------------
		if (!s.rvalid && arvalid) begin
			case (araddr)
			A_CTRL: rd = 32'h0;
			A_STATUS: rd = {27'h0, s.state != S_IDLE, s.state};
			A_SEG: rd = s.seg_reg;
			A_CUR: rd = s.cur_ptr;
			A_TIMER: rd = s.timer;
			A_SEM: rd = {s.fetched[F_SEMSEG], s.fetched[F_SEMOFS]};
			A_ABORT: rd = {s.fetched[F_ABORT], s.fetched[F_REGSET]};
			A_DESCRIPTOR_TABLE_ADDR_2: rd = {s.fetched[F_DESCRIPTOR_TABLE_ADDR_2], s.fetched[F_DESCRIPTOR_TABLE_ADDR_2+1]};
			A_DESCRIPTOR_TABLE_ADDR_3: rd = {s.fetched[F_DESCRIPTOR_TABLE_ADDR_3], s.fetched[F_DESCRIPTOR_TABLE_ADDR_3+1]};
			A_MASK: rd = {11'h0, reg_count, s.fetched[F_MASK]};
			A_PAGEV: rd = {s.fetched[F_PAGEV], s.fetched[F_PAGEV+1]};
			A_FSTK: rd = {s.fetched[F_FSTK], s.fetched[F_FSTK+1]};
			A_FSTKL: rd = {16'h0, s.fetched[F_FSTK+2]};
			A_IRQS: begin
				rd = {26'h0, s.irq_stat};
				next_s.irq_stat = '0;
			end
			A_IRQM: rd = {26'h0, s.irq_mask};
			default: hit = 1'b0;
			endcase
			next_s.rvalid = 1'b1;
			next_s.rdata = rd;
			next_s.rresp = hit ? RESP_OKAY : RESP_SLVERR;
		end
		// An event in the clearing cycle survives the clear.
		next_s.irq_stat = next_s.irq_stat | ev;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------
	assign awready = !s.aw_have;
	assign wready = !s.w_have;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = !s.rvalid;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign mem_req = s.mem;
	assign irq = |(s.irq_stat & s.irq_mask);

	// ----------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	seg_source_a: assert property (
		s.mem.valid |-> s.mem.seg == s.seg_reg[31:16])
		else $error("memory access outside descriptor segment");
	end_stop_a: assert property (
		s.state == S_HDR_DATA && mem_rsp.rvalid &&
		mem_rsp.rdata == END_MARK
		|=> s.state == S_IDLE && s.cur_ptr[15:0] == NO_DESC &&
		s.irq_stat[EV_IDLE])
		else $error("end marker did not stop the walk");
	empty_skip_a: assert property (
		s.state == S_HDR_DATA && mem_rsp.rvalid &&
		mem_rsp.rdata == EMPTY_MARK
		|=> s.state == S_HDR && s.level == $past(s.level) + HDR_STEP
		&& s.mem.off == s.level)
		else $error("empty level not skipped to next header");
	dtar_nosave_a: assert property (
		s.mem.valid && s.mem.we |->
		!(s.mem.off >= word_at(s.cur_ptr[15:0], DTAR_FIRST) &&
		s.mem.off <= word_at(s.cur_ptr[15:0], DTAR_LAST)))
		else $error("table address words were written");
	abort_fault_a: assert property (
		s.state == S_CHECK && s.fetched[F_SEMSEG] == 16'h0000 &&
		s.fetched[F_ABORT] != 16'h0000
		|=> s.irq_stat[EV_ABORT] && $stable(s.cur_ptr[15:0]))
		else $error("abort flags did not block dispatch");
	timer_save_a: assert property (
		s.state == S_SAVE_HI && mem_rsp.ready
		|-> s.mem.we && s.mem.off == word_at(s.cur_ptr[15:0],
		TIMER_HI_OFS) ##1 s.mem.we &&
		s.mem.off == word_at(s.cur_ptr[15:0], TIMER_LO_OFS))
		else $error("timer copy written to wrong words");
	cur_ptr_a: assert property (
		s.state == S_CHECK && s.fetched[F_SEMSEG] == 16'h0000 &&
		s.fetched[F_ABORT] == 16'h0000
		|=> s.cur_ptr == {$past(s.level), $past(s.cand)} &&
		s.irq_stat[EV_DISPATCH])
		else $error("current pointer not loaded on dispatch");
	waiting_a: assert property (
		s.state == S_CHECK && s.fetched[F_SEMSEG] != 16'h0000
		|=> s.irq_stat[EV_WAITING] && !s.irq_stat[EV_DISPATCH] ||
		$past(s.irq_stat[EV_DISPATCH]))
		else $error("waiting process was dispatched");

endmodule

// [tb/desc_memory.sv]
// Behavioural descriptor memory on the far side of the dispatch engine.
`timescale 1ns/1ps
module desc_memory
	import dispatch_pkg::*;
(
	// Clock
	input wire logic aclk,
	// Engine side
	input wire mem_req_t mem_req,
	output mem_rsp_t mem_rsp,
	// Pacing
	input wire logic slow
);
	// -----------------------------------------------------------
	// Storage and answer logic
	// -----------------------------------------------------------
	logic [15:0] mem [0:255];
	logic [15:0] last_seg;
	logic [15:0] held;
	logic busy;
	int wait_n;
	int n_writes;
	initial begin
		mem_rsp = '{1'b1, 1'b0, 16'h0000};
		last_seg = 16'h0000;
		held = 16'h0000;
		busy = 1'b0;
		wait_n = 0;
		n_writes = 0;
	end
	// Stale data is inverted every idle cycle so that a late sample never
	// happens to match.
	always @(posedge aclk) begin
		if (busy) begin
			if (wait_n == 0) begin
				mem_rsp.rvalid <= 1'b1;
				mem_rsp.rdata <= held;
				mem_rsp.ready <= 1'b1;
				busy <= 1'b0;
			end else begin
				wait_n <= wait_n - 1;
			end
		end else begin
			mem_rsp.rvalid <= 1'b0;
			mem_rsp.rdata <= ~mem_rsp.rdata;
			if (mem_req.valid && mem_rsp.ready) begin
				last_seg <= mem_req.seg;
				if (mem_req.we) begin
					mem[mem_req.off[7:0]] <= mem_req.wdata;
					n_writes++;
				end else begin
					held <= mem[mem_req.off[7:0]];
					busy <= 1'b1;
					wait_n <= slow ? 3 : 0;
					mem_rsp.ready <= 1'b0;
				end
			end
		end
	end
endmodule

// [tb/process_dispatch_tb.sv]
// Self-checking bench for the process dispatch engine.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		errors++; \
		$display("MISMATCH %s exp %h got %h", nm, (e), (g)); \
	end \
end
module process_dispatch_tb
	import dispatch_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic slow = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, rd;
	mem_req_t mem_req;
	mem_rsp_t mem_rsp;
	int errors = 0;
	int n_compared = 0;
	logic [7:0] ra [0:7] = '{A_SEM, A_ABORT, A_DESCRIPTOR_TABLE_ADDR_2, A_DESCRIPTOR_TABLE_ADDR_3, A_MASK,
		A_PAGEV, A_FSTK, A_FSTKL};
	logic [31:0] rv [0:7] = '{32'h0, 32'h0000_1234, 32'hA00A_A00B,
		32'hA00C_A00D, 32'h0008_F00F, 32'hB03A_B03B, 32'hB03C_B03D,
		32'h0000_B03E};

	always #12.5 aclk = ~aclk;

	process_dispatch process_dispatch_inst (.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.mem_req(mem_req), .mem_rsp(mem_rsp), .irq(irq));
	desc_memory desc_memory_inst (.aclk(aclk), .mem_req(mem_req),
		.mem_rsp(mem_rsp), .slow(slow));

	// -----------------------------------------------------------
	// Bus tasks
	// -----------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rdr(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rdr(a);
		`CHK($sformatf("reg %h", a), e, rd)
	endtask

	// A fixed settle lets the start command land before busy is polled.
	task automatic wait_idle();
		int t;
		t = 0;
		repeat (2) @(posedge aclk);
		do begin
			rdr(A_STATUS);
			t++;
		end while (rd[4] !== 1'b0 && t < 200);
		`CHK("busy", 1'b0, rd[4])
	endtask

	task automatic go(input logic [15:0] lv);
		wr(A_CUR, {lv, 16'h0000}, 4'hF);
		wr(A_CTRL, 32'h0000_0001, 4'hF);
		wait_idle();
	endtask

	task automatic put(input int o, input logic [15:0] v);
		desc_memory_inst.mem[o] = v;
	endtask

	task automatic results();
		if (errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// -----------------------------------------------------------
	// Tests
	// -----------------------------------------------------------
	initial begin
		for (int i = 0; i < 256; i++) put(i, 16'h0000);
		put(2, 16'h0040);
		put(3, 16'h0040);
		put(4, 16'h0080);
		put(6, 16'h00C0);
		put(8, 16'h0001);
		put(64, 16'h0002);
		put(69, 16'h1234);
		for (int i = 10; i < 14; i++) put(64 + i, 16'(16'hA000 + i));
		put(78, 16'h0012);
		put(80, 16'hF00F);
		for (int i = 58; i < 63; i++) put(64 + i, 16'(16'hB000 + i));
		put(128, 16'h0006);
		put(132, 16'h0001);
		put(192, 16'h0006);
		put(194, 16'h0007);
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk(A_CUR, 32'h0);
		rchk(A_IRQS, 32'h0);
		`CHK("irq", 1'b0, irq)
		rdr(8'h3C);
		`CHK("rresp", RESP_SLVERR, rs)
		`CHK("rdata", 32'h0, rd)
		wr(8'h3C, 32'hFFFF_FFFF, 4'hF);
		`CHK("bresp", RESP_SLVERR, rs)
		wr(A_SEG, 32'h0005_FFFF, 4'hC);
		`CHK("bresp", RESP_OKAY, rs)
		rdr(A_SEG);
		`CHK("seg", 32'h0005_0000, rd)
		wr(A_IRQM, 32'h3F, 4'hF);
		go(16'h0000);
		rchk(A_CUR, 32'h0002_0040);
		`CHK("mem seg", 16'h0005, desc_memory_inst.last_seg)
		`CHK("irq", 1'b1, irq)
		rchk(A_IRQS, 32'h01);
		rchk(A_IRQS, 32'h00);
		`CHK("irq", 1'b0, irq)
		for (int i = 0; i < 8; i++) begin
			rchk(ra[i], rv[i]);
		end
		rdr(A_TIMER);
		`CHK("timer", 16'h0012, rd[31:16])
		wr(A_CTRL, 32'h0000_0002, 4'hF);
		wait_idle();
		`CHK("saves", 2, desc_memory_inst.n_writes)
		`CHK("hi", 16'h0012, desc_memory_inst.mem[78])
		`CHK("dtar", 16'hA00A, desc_memory_inst.mem[74])
		slow <= 1'b1;
		go(16'h0004);
		rchk(A_IRQS, 32'h24);
		slow <= 1'b0;
		go(16'h0006);
		rchk(A_IRQS, 32'h08);
		wr(A_IRQM, 32'h0, 4'hF);
		go(16'h0008);
		`CHK("irq", 1'b0, irq)
		wr(A_IRQM, 32'h3F, 4'hF);
		`CHK("irq", 1'b1, irq)
		rchk(A_IRQS, 32'h02);
		rdr(A_CUR);
		`CHK("desc", 16'h0000, rd[15:0])
		wr(A_CTRL, 32'h0000_0002, 4'hF);
		rchk(A_STATUS, 32'h0);
		`CHK("saves", 2, desc_memory_inst.n_writes)
		wr(A_TIMER, 32'h1234_5678, 4'hF);
		rchk(A_TIMER, 32'h1234_5678);
		put(78, 16'hFFFF);
		put(79, 16'hFFF0);
		go(16'h0000);
		repeat (40) @(posedge aclk);
		rchk(A_IRQS, 32'h11);
		results();
	end

	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		results();
	end
endmodule
